/* hdl/utopia_rx_pkg.sv */
// shared types, constants and helper functions of the receive cell port
package utopia_rx_pkg;
  localparam int DATA_W = 16;
  localparam int CELL_PTR_W = 5;
  localparam int CELL_IDX_W = 4;
  localparam int WORD_IDX_W = 6;
  localparam int MEM_AW = CELL_IDX_W + WORD_IDX_W;
  localparam int ADDR_W = 5;
  localparam logic [CELL_PTR_W-1:0] FIFO_CELLS = 5'h10;
  localparam logic [CELL_PTR_W-1:0] PTR_ONE = 5'h01;
  localparam logic [WORD_IDX_W-1:0] IDX_ZERO = 6'h00;
  localparam logic [WORD_IDX_W-1:0] IDX_ONE = 6'h01;
  localparam int SYS_CLK_MHZ = 25;
  localparam int LINK_CLK_MAX_MHZ = 50;

  localparam logic [1:0] BW_OFF = 2'h0;
  localparam logic [1:0] BW_8 = 2'h1;
  localparam logic [1:0] BW_16 = 2'h2;
  localparam logic [1:0] CS_52 = 2'h0;
  localparam logic [1:0] CS_53 = 2'h1;
  localparam logic [1:0] CS_54 = 2'h2;
  localparam logic [WORD_IDX_W-1:0] BYTES_52 = 6'h34;
  localparam logic [WORD_IDX_W-1:0] BYTES_53 = 6'h35;
  localparam logic [WORD_IDX_W-1:0] BYTES_54 = 6'h36;
  localparam logic LEVEL_3 = 1'b0;
  localparam logic LEVEL_12 = 1'b1;
  localparam logic HS_OCTET = 1'b0;
  localparam logic HS_CELL = 1'b1;

  // configuration byte; handshake mode sits at bit 5
  typedef struct packed {
    logic       level_sel;
    logic       multi_phy;
    logic       handshake;
    logic       pll_en;
    logic [1:0] bus_width;
    logic [1:0] cell_size;
  } rx_cfg_t;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic              sof;
    logic              eoc;
    logic              discard;
  } up_word_t;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_FILL = 2'b01,
    WR_SKIP = 2'b11
  } wr_state_t;

  function automatic logic bus_on(input logic [1:0] bw);
    bus_on = (bw == BW_8) || (bw == BW_16);
  endfunction : bus_on

  // 53 is only meaningful on the byte bus; on the word bus it falls back to 52
  function automatic logic [WORD_IDX_W-1:0] cell_words(input logic [1:0] bw,
                                                       input logic [1:0] cs);
    logic [WORD_IDX_W-1:0] bytes;
    bytes = (cs == CS_54) ? BYTES_54 : ((cs == CS_53) ? BYTES_53 : BYTES_52);
    if (bw == BW_16) begin
      cell_words = (cs == CS_53) ? (BYTES_52 >> 1) : (bytes >> 1);
    end else begin
      cell_words = bytes;
    end
  endfunction : cell_words

  function automatic logic [CELL_PTR_W-1:0] bin2gray(input logic [CELL_PTR_W-1:0] b);
    bin2gray = b ^ (b >> 1);
  endfunction : bin2gray

  function automatic logic [CELL_PTR_W-1:0] gray2bin(input logic [CELL_PTR_W-1:0] g);
    logic [CELL_PTR_W-1:0] b;
    b = '0;
    b[CELL_PTR_W-1] = g[CELL_PTR_W-1];
    for (int i = CELL_PTR_W - 2; i >= 0; i--) begin
      b[i] = g[i] ^ b[i+1];
    end
    gray2bin = b;
  endfunction : gray2bin
endpackage : utopia_rx_pkg

/* hdl/level_sync.sv */
// two-flop synchroniser for levels and gray-coded pointers
module level_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= '0;
      q_o    <= '0;
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end
endmodule : level_sync

/* hdl/cell_mem.sv */
// sixteen-slot cell storage, written on the upstream clock, read asynchronously
module cell_mem
  import utopia_rx_pkg::*;
(
  input  wire logic              wr_clk_i,
  input  wire logic              wr_en_i,
  input  wire logic [MEM_AW-1:0] wr_addr_i,
  input  wire logic [DATA_W-1:0] wr_data_i,
  input  wire logic [MEM_AW-1:0] rd_addr_i,
  output logic      [DATA_W-1:0] rd_data_o
);
  logic [DATA_W-1:0] mem [2**MEM_AW];

  always_ff @(posedge wr_clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  // a slot is only read after its commit crossed over, so it is stable
  assign rd_data_o = mem[rd_addr_i];
endmodule : cell_mem

/* hdl/utopia_rx_port.sv */
// receive cell port: upstream cell writer, dual-clock cell fifo, reader-side bus
// Functional notes
// RQ1 - octet handshake single-PHY only; multi-PHY cell-level
// RQ2 - handshake mode from configuration bit five
// RQ3 - read bus width eight or sixteen bits
// RQ4 - only undiscarded cells written, upstream clock
// RQ5 - cell available high while data waits
// RQ6 - odd parity driven with each word
// RQ7 - cell size 52/53/54, start-of-cell marked
// RQ8 - short cell: interrupt, drop it, continue
// RQ9 - fifo holds exactly sixteen cells
// RQ10 - fifo empty and full reported as status
// RQ11 - deskew pll enable and port address set
// RQ12 - address inputs latched on link clock, multi-PHY
// RQ13 - 8-bit uses low lanes; 16-bit all
// RQ14 - data bus released while read enable high
// RQ15 - reader drives read enable low to read
// RQ16 - data updated on link clock rising edge
// RQ17 - link clock at most 50 MHz
// RQ18 - start-of-cell one cycle on first word
// RQ19 - level 1, 2 or 3 signalling supported
// RQ20 - level bit: 0 level 3, 1 levels 1/2
// RQ21 - width code 00 off, 01 eight, 10 sixteen
// RQ22 - size code 00 52, 01 53, 10 54
// RQ23 - cell-level: available only with full cell left
// RQ24 - cells leave in write order, never interleaved
// RQ25 - fill pointers cross domains gray-coded, synchronised
module utopia_rx_port
  import utopia_rx_pkg::*;
(
  input  wire logic              sys_clk_i,
  input  wire logic              sys_rst_i,
  input  wire rx_cfg_t           rx_config_i,
  input  wire logic [ADDR_W-1:0] rx_port_address_cfg_i,
  input  wire logic              up_valid_i,
  input  wire up_word_t          up_word_i,
  output logic                   up_ready_o,
  output logic                   fifo_empty_o,
  output logic                   fifo_full_o,
  output logic                   runt_irq_o,
  output logic                   rx_deskew_pll_en_o,
  input  wire logic              rx_interface_clock_i,
  input  wire logic              rx_read_enable_n_i,
  input  wire logic [ADDR_W-1:0] rx_port_address_in_i,
  output logic      [DATA_W-1:0] rx_cell_data_bus_o,
  output logic      [1:0]        rx_cell_data_bus_oe_o,
  output logic                   rx_odd_parity_out_o,
  output logic                   rx_odd_parity_out_oe_o,
  output logic                   rx_start_of_cell_o,
  output logic                   rx_cell_available_o,
  output logic                   rx_cell_available_oe_o
);
  // ---------------- upstream (system clock) side ----------------
  wr_state_t             wr_state_r;
  logic [WORD_IDX_W-1:0] widx_r;
  logic [CELL_PTR_W-1:0] wptr_r;
  logic [CELL_PTR_W-1:0] wptr_gray_r;
  logic [CELL_PTR_W-1:0] rptr_gray_sys;
  logic [CELL_PTR_W-1:0] rptr_sys;
  logic [CELL_PTR_W-1:0] fill_sys;
  logic [WORD_IDX_W-1:0] words_sys;
  logic                  full_c;
  logic                  wr_fire;
  logic                  mem_we;
  logic [MEM_AW-1:0]     mem_waddr;
  logic [DATA_W-1:0]     mem_wdata;
  logic [MEM_AW-1:0]     mem_raddr;
  logic [DATA_W-1:0]     mem_rdata;

  level_sync #(.W(CELL_PTR_W)) u_rptr_sync (
    .clk_i (sys_clk_i),
    .rst_i (sys_rst_i),
    .d_i   (rptr_gray_r),
    .q_o   (rptr_gray_sys)
  );

  assign rptr_sys  = gray2bin(rptr_gray_sys);
  assign fill_sys  = wptr_r - rptr_sys;
  assign full_c    = (fill_sys == FIFO_CELLS); // RQ9
  assign words_sys = cell_words(rx_config_i.bus_width, rx_config_i.cell_size); // RQ7 RQ22
  // back-pressure: a full fifo stalls the upstream processor
  assign up_ready_o = ~full_c;
  assign wr_fire    = up_valid_i && up_ready_o;

  // RQ4
  assign mem_we    = wr_fire && !up_word_i.discard && (up_word_i.sof || wr_state_r == WR_FILL);
  assign mem_waddr = {wptr_r[CELL_IDX_W-1:0], (up_word_i.sof ? IDX_ZERO : widx_r)};
  assign mem_wdata = (rx_config_i.bus_width == BW_16) ? up_word_i.data
                                                      : {8'h00, up_word_i.data[7:0]};

  cell_mem u_mem (
    .wr_clk_i  (sys_clk_i),
    .wr_en_i   (mem_we),
    .wr_addr_i (mem_waddr),
    .wr_data_i (mem_wdata),
    .rd_addr_i (mem_raddr),
    .rd_data_o (mem_rdata)
  );

  // cell framing on the write side; a cell is committed only when complete
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      wr_state_r <= WR_IDLE;
      widx_r     <= IDX_ZERO;
      wptr_r     <= '0;
      runt_irq_o <= 1'b0;
    end else begin
      runt_irq_o <= 1'b0;
      if (wr_fire) begin
        if (up_word_i.sof) begin
          // a new cell while one is still short: the old one is a runt
          runt_irq_o <= (wr_state_r == WR_FILL) || up_word_i.eoc; // RQ8
          widx_r     <= IDX_ONE;
          if (up_word_i.discard || up_word_i.eoc) begin
            wr_state_r <= WR_SKIP; // RQ4
          end else if (words_sys == IDX_ONE) begin
            wptr_r     <= wptr_r + PTR_ONE;
            wr_state_r <= WR_IDLE;
          end else begin
            wr_state_r <= WR_FILL;
          end
        end else if (wr_state_r == WR_FILL) begin
          if (up_word_i.discard) begin
            wr_state_r <= WR_SKIP; // RQ4
          end else if (widx_r == words_sys - IDX_ONE) begin
            wptr_r     <= wptr_r + PTR_ONE; // RQ24
            // surplus words of an over-long cell are thrown away
            wr_state_r <= up_word_i.eoc ? WR_IDLE : WR_SKIP;
          end else if (up_word_i.eoc) begin
            runt_irq_o <= 1'b1; // RQ8
            wr_state_r <= WR_IDLE;
          end else begin
            widx_r <= widx_r + IDX_ONE;
          end
        end else if (up_word_i.eoc) begin
          wr_state_r <= WR_IDLE;
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      wptr_gray_r <= '0;
    end else begin
      wptr_gray_r <= bin2gray(wptr_r); // RQ25
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      fifo_empty_o       <= 1'b1;
      fifo_full_o        <= 1'b0;
      rx_deskew_pll_en_o <= 1'b0;
    end else begin
      fifo_empty_o       <= (fill_sys == '0); // RQ10
      fifo_full_o        <= full_c; // RQ10
      rx_deskew_pll_en_o <= rx_config_i.pll_en; // RQ11
    end
  end

  // ---------------- reader (link clock) side ----------------
  logic                  rst_link;
  logic [CELL_PTR_W-1:0] wptr_gray_link;
  logic [CELL_PTR_W-1:0] wptr_link;
  logic [CELL_PTR_W-1:0] rptr_r;
  logic [CELL_PTR_W-1:0] rptr_gray_r;
  logic [WORD_IDX_W-1:0] ridx_r;
  logic [CELL_PTR_W-1:0] avail;
  rx_cfg_t               cfg_link;
  logic [ADDR_W-1:0]     port_addr_link;
  logic [ADDR_W-1:0]     addr_in_r;
  logic                  multi_eff;
  logic                  cell_hs;
  logic                  selected;
  logic                  rd_fire;
  logic [WORD_IDX_W-1:0] words_link;
  logic                  wide;

  // two register stages per link path keep this side within the 50 MHz ceiling
  level_sync #(.W(1)) u_rst_sync ( // RQ17
    .clk_i (rx_interface_clock_i),
    .rst_i (1'b0),
    .d_i   (sys_rst_i),
    .q_o   (rst_link)
  );

  level_sync #(.W(CELL_PTR_W)) u_wptr_sync (
    .clk_i (rx_interface_clock_i),
    .rst_i (rst_link),
    .d_i   (wptr_gray_r),
    .q_o   (wptr_gray_link)
  ); // RQ25

  // configuration is quasi-static; change it only while the port is idle
  level_sync #(.W($bits(rx_cfg_t) + ADDR_W)) u_cfg_sync (
    .clk_i (rx_interface_clock_i),
    .rst_i (rst_link),
    .d_i   ({rx_config_i, rx_port_address_cfg_i}),
    .q_o   ({cfg_link, port_addr_link})
  );

  assign wptr_link  = gray2bin(wptr_gray_link);
  assign avail      = wptr_link - rptr_r;
  assign words_link = cell_words(cfg_link.bus_width, cfg_link.cell_size); // RQ7
  assign wide       = (cfg_link.bus_width == BW_16); // RQ3 RQ21
  // level 3 is point to point, so multi-PHY only applies at levels 1/2
  assign multi_eff  = cfg_link.multi_phy && (cfg_link.level_sel == LEVEL_12); // RQ19 RQ20
  assign cell_hs    = multi_eff || (cfg_link.handshake == HS_CELL); // RQ1 RQ2
  assign selected   = !multi_eff || (addr_in_r == port_addr_link); // RQ11
  assign rd_fire    = !rx_read_enable_n_i && selected && bus_on(cfg_link.bus_width)
                      && (avail != '0); // RQ15
  assign mem_raddr  = {rptr_r[CELL_IDX_W-1:0], ridx_r}; // RQ24

  always_ff @(posedge rx_interface_clock_i) begin
    if (rst_link) begin
      addr_in_r <= '0;
    end else if (multi_eff) begin
      addr_in_r <= rx_port_address_in_i; // RQ12
    end
  end

  // whole cells are drained in order before the pointer moves on
  always_ff @(posedge rx_interface_clock_i) begin
    if (rst_link) begin
      rptr_r <= '0;
      ridx_r <= IDX_ZERO;
    end else if (rd_fire) begin
      if (ridx_r == words_link - IDX_ONE) begin
        rptr_r <= rptr_r + PTR_ONE; // RQ24
        ridx_r <= IDX_ZERO;
      end else begin
        ridx_r <= ridx_r + IDX_ONE;
      end
    end
  end

  always_ff @(posedge rx_interface_clock_i) begin
    if (rst_link) begin
      rptr_gray_r <= '0;
    end else begin
      rptr_gray_r <= bin2gray(rptr_r); // RQ25
    end
  end

  // data, parity and start-of-cell all move together on the rising edge
  always_ff @(posedge rx_interface_clock_i) begin
    if (rst_link) begin
      rx_cell_data_bus_o  <= '0;
      rx_odd_parity_out_o <= 1'b1;
      rx_start_of_cell_o  <= 1'b0;
    end else begin
      rx_start_of_cell_o <= rd_fire && (ridx_r == IDX_ZERO); // RQ18
      if (rd_fire) begin
        rx_cell_data_bus_o <= wide ? mem_rdata : {8'h00, mem_rdata[7:0]}; // RQ13 RQ16
        rx_odd_parity_out_o <= wide ? ~^mem_rdata : ~^mem_rdata[7:0]; // RQ6
      end
    end
  end

  always_ff @(posedge rx_interface_clock_i) begin
    if (rst_link) begin
      rx_cell_available_o <= 1'b0;
    end else if (!bus_on(cfg_link.bus_width)) begin
      rx_cell_available_o <= 1'b0;
    end else if (cell_hs) begin
      // only a whole unread cell counts once reading has begun
      rx_cell_available_o <= (avail > PTR_ONE) ||
                             ((avail == PTR_ONE) && (ridx_r == IDX_ZERO)); // RQ23
    end else begin
      rx_cell_available_o <= (avail != '0); // RQ5
    end
  end

  // bus released whenever the reader is not enabling it
  always_comb begin
    rx_cell_data_bus_oe_o  = 2'b00;
    rx_odd_parity_out_oe_o = 1'b0;
    if (!rx_read_enable_n_i && selected && bus_on(cfg_link.bus_width) && !rst_link) begin
      rx_cell_data_bus_oe_o  = {wide, 1'b1}; // RQ13 RQ14
      rx_odd_parity_out_oe_o = 1'b1; // RQ14
    end
  end

  // on a shared multi-PHY bus only the addressed port drives the flag
  assign rx_cell_available_oe_o = !rst_link && selected;
endmodule : utopia_rx_port

/* verif/utopia_rx_port_asserts.sv */
// concurrent checks on the receive cell port pins
module utopia_rx_port_asserts
  import utopia_rx_pkg::*;
(
  input wire logic              sys_clk_i,
  input wire logic              sys_rst_i,
  input wire rx_cfg_t           rx_config_i,
  input wire logic              up_valid_i,
  input wire logic              fifo_empty_o,
  input wire logic              fifo_full_o,
  input wire logic              runt_irq_o,
  input wire logic              rx_interface_clock_i,
  input wire logic              rx_read_enable_n_i,
  input wire logic [DATA_W-1:0] rx_cell_data_bus_o,
  input wire logic [1:0]        rx_cell_data_bus_oe_o,
  input wire logic              rx_odd_parity_out_o,
  input wire logic              rx_odd_parity_out_oe_o,
  input wire logic              rx_start_of_cell_o
);
  timeunit 1ns;
  timeprecision 1ps;
  wide_lanes_a: assert property (@(posedge rx_interface_clock_i) disable iff (sys_rst_i)
    !rx_read_enable_n_i && !rx_config_i.multi_phy && rx_config_i.bus_width == BW_16
    |-> rx_cell_data_bus_oe_o == 2'h3) else $error("word bus not fully driven");
  parity_oe_a: assert property (@(posedge rx_interface_clock_i) disable iff (sys_rst_i)
    rx_cell_data_bus_oe_o[0] |-> rx_odd_parity_out_oe_o) else $error("parity not driven with data");
  bus_release_a: assert property (@(posedge rx_interface_clock_i) disable iff (sys_rst_i)
    rx_read_enable_n_i |-> rx_cell_data_bus_oe_o == 2'h0) else $error("bus driven while idle");
  // idle upper byte is zero in byte mode, so parity over all lanes stays valid
  odd_parity_a: assert property (@(posedge rx_interface_clock_i) disable iff (sys_rst_i)
    rx_cell_data_bus_oe_o[0] |-> ^{rx_cell_data_bus_o, rx_odd_parity_out_o}) else $error("even parity");
  narrow_lane_a: assert property (@(posedge rx_interface_clock_i) disable iff (sys_rst_i)
    rx_config_i.bus_width == BW_8 |-> !rx_cell_data_bus_oe_o[1]) else $error("upper lane driven");
  width_off_a: assert property (@(posedge rx_interface_clock_i) disable iff (sys_rst_i)
    rx_config_i.bus_width == BW_OFF |-> rx_cell_data_bus_oe_o == 2'h0) else $error("bus on while off");
  soc_single_a: assert property (@(posedge rx_interface_clock_i) disable iff (sys_rst_i)
    rx_start_of_cell_o |=> !rx_start_of_cell_o) else $error("start of cell too long");
  soc_cause_a: assert property (@(posedge rx_interface_clock_i) disable iff (sys_rst_i)
    $rose(rx_start_of_cell_o) |-> $past(rx_read_enable_n_i) == 1'b0) else $error("start without read");
  data_hold_a: assert property (@(posedge rx_interface_clock_i) disable iff (sys_rst_i)
    $past(rx_read_enable_n_i) |-> $stable(rx_cell_data_bus_o)) else $error("data moved without read");
  runt_cause_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    runt_irq_o |-> $past(up_valid_i)) else $error("runt flag without word");
  status_excl_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    !(fifo_empty_o && fifo_full_o)) else $error("empty and full together");
  soc_seen_c: cover property (@(posedge rx_interface_clock_i) rx_start_of_cell_o);
  runt_seen_c: cover property (@(posedge sys_clk_i) runt_irq_o);
  full_seen_c: cover property (@(posedge sys_clk_i) fifo_full_o);
endmodule : utopia_rx_port_asserts

bind utopia_rx_port utopia_rx_port_asserts i_utopia_rx_port_asserts (.sys_clk_i, .sys_rst_i,
  .rx_config_i, .up_valid_i, .fifo_empty_o, .fifo_full_o, .runt_irq_o, .rx_interface_clock_i,
  .rx_read_enable_n_i, .rx_cell_data_bus_o, .rx_cell_data_bus_oe_o, .rx_odd_parity_out_o,
  .rx_odd_parity_out_oe_o, .rx_start_of_cell_o);

/* verif/atm_reader_model.sv */
// reader model: pulls whole cells over the receive bus, may stall
module atm_reader_model
  import utopia_rx_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  want_i,
  input  wire logic [WORD_IDX_W-1:0] words_i,
  input  wire logic                  clav_i,
  input  wire logic [DATA_W-1:0]     data_i,
  input  wire logic                  soc_i,
  input  wire logic                  par_i,
  output logic                       enb_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [WORD_IDX_W-1:0] left_r = '0;
  logic                  rd_r   = 1'b0;
  logic                  rd_d_r = 1'b0;
  logic                  enb_r  = 1'b1;
  logic [DATA_W+1:0]     got [$];
  assign enb_n_o = enb_r;
  // enable is seen one edge after it drops and the word shows after that edge,
  // so capture two edges after the request
  always @(posedge clk_i) begin
    if (rd_d_r) got.push_back({soc_i, par_i, data_i});
    rd_d_r <= rd_r;
    rd_r   <= 1'b0;
    enb_r  <= 1'b1;
    if (rst_i) begin
      left_r <= '0;
    // new cell only on a settled clav, then stays in it, so cells are never split
    end else if (want_i && (left_r != '0 || (clav_i && !rd_r && !rd_d_r))) begin
      rd_r   <= 1'b1;
      enb_r  <= 1'b0;
      left_r <= (left_r != '0) ? left_r - 1'b1 : words_i - 1'b1;
    end
  end
endmodule : atm_reader_model

/* verif/tb_top.sv */
// self-checking bench for the receive cell port
module tb_top
  import utopia_rx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              sys_clk_i = 0, sys_rst_i = 1, rx_interface_clock_i = 0, up_valid_i = 0;
  rx_cfg_t           rx_config_i = '{LEVEL_12, 1'b0, HS_CELL, 1'b1, BW_OFF, CS_52};
  logic [ADDR_W-1:0] rx_port_address_cfg_i = 5'h03, rx_port_address_in_i = 5'h03;
  up_word_t          up_word_i = '0;
  logic              up_ready_o, fifo_empty_o, fifo_full_o, runt_irq_o, rx_deskew_pll_en_o;
  logic              rx_read_enable_n_i, rx_start_of_cell_o, rx_cell_available_o;
  logic              rx_cell_available_oe_o, rx_odd_parity_out_o, rx_odd_parity_out_oe_o;
  logic [DATA_W-1:0] rx_cell_data_bus_o;
  logic [1:0]        rx_cell_data_bus_oe_o;
  logic              want = 0;
  logic [5:0]        words = 6'h34;
  logic [1:0]        widths [5] = '{BW_8, BW_8, BW_8, BW_16, BW_16};
  logic [1:0]        sizes [5] = '{CS_52, CS_53, CS_54, CS_52, CS_54};
  logic [5:0]        counts [5] = '{6'h34, 6'h35, 6'h36, 6'h1a, 6'h1b};
  int                fail_count = 0, check_count = 0, irq_seen = 0;

  utopia_rx_port i_utopia_rx_port (.sys_clk_i, .sys_rst_i, .rx_config_i, .rx_port_address_cfg_i,
    .up_valid_i, .up_word_i, .up_ready_o, .fifo_empty_o, .fifo_full_o, .runt_irq_o,
    .rx_deskew_pll_en_o, .rx_interface_clock_i, .rx_read_enable_n_i, .rx_port_address_in_i,
    .rx_cell_data_bus_o, .rx_cell_data_bus_oe_o, .rx_odd_parity_out_o, .rx_odd_parity_out_oe_o,
    .rx_start_of_cell_o, .rx_cell_available_o, .rx_cell_available_oe_o);
  // a deselected clav line reads as low at the reader
  atm_reader_model i_atm_reader_model (.clk_i(rx_interface_clock_i), .rst_i(sys_rst_i),
    .want_i(want), .words_i(words), .clav_i(rx_cell_available_o & rx_cell_available_oe_o),
    .data_i(rx_cell_data_bus_o), .soc_i(rx_start_of_cell_o), .par_i(rx_odd_parity_out_o),
    .enb_n_o(rx_read_enable_n_i));

  initial forever #20 sys_clk_i = ~sys_clk_i;
  initial begin
    #7;
    forever #32 rx_interface_clock_i = ~rx_interface_clock_i;
  end
  always @(posedge sys_clk_i) if (runt_irq_o === 1'b1) irq_seen++;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict

  // ready is held between edges, so a word seen ready at the falling edge is taken
  task automatic send_cell(input logic [7:0] base, input logic [5:0] n, input logic disc);
    for (int i = 0; i < n; i++) begin
      do @(negedge sys_clk_i); while (up_ready_o !== 1'b1);
      up_valid_i = 1'b1;
      up_word_i = '{{base, base + i[7:0]}, i == 0, i == n - 1, disc};
    end
    @(negedge sys_clk_i);
    up_valid_i = 1'b0;
  endtask : send_cell

  task automatic expect_cell(input logic [7:0] base, input logic [5:0] n, input logic wide);
    logic [DATA_W+1:0] w;
    logic [DATA_W-1:0] d;
    for (int i = 0; i < n; i++) begin
      for (int t = 0; t < 4000 && i_atm_reader_model.got.size() == 0; t++) @(posedge sys_clk_i);
      w = (i_atm_reader_model.got.size() > 0) ? i_atm_reader_model.got.pop_front() : 'x;
      d = wide ? {base, base + i[7:0]} : {8'h00, base + i[7:0]};
      check(w, {i == 0, ~^d, d});
    end
  endtask : expect_cell

  initial begin
    repeat (10) @(negedge sys_clk_i);
    sys_rst_i = 0;
    repeat (8) @(negedge sys_clk_i);
    check({up_ready_o, fifo_empty_o, fifo_full_o, rx_deskew_pll_en_o}, 4'hd);
    $display("test reset done");
    for (int k = 0; k < 5; k++) begin
      rx_config_i.bus_width = widths[k];
      rx_config_i.cell_size = sizes[k];
      words = counts[k];
      repeat (8) @(negedge sys_clk_i);
      send_cell(8'(k * 16), counts[k], 1'b0);
      repeat (12) @(negedge sys_clk_i);
      check({fifo_empty_o, rx_cell_available_o}, 2'h1);
      want = 1;
      expect_cell(8'(k * 16), counts[k], widths[k] == BW_16);
      repeat (12) @(negedge sys_clk_i);
      check({fifo_empty_o, rx_cell_available_o}, 2'h2);
      want = 0;
    end
    $display("test sizes done");
    rx_config_i.bus_width = BW_8;
    rx_config_i.cell_size = CS_52;
    words = 6'h34;
    repeat (8) @(negedge sys_clk_i);
    send_cell(8'h60, 6'h34, 1'b1);
    send_cell(8'h70, 6'h0a, 1'b0);
    send_cell(8'h80, 6'h34, 1'b0);
    want = 1;
    expect_cell(8'h80, 6'h34, 1'b0);
    check(irq_seen, 1);
    want = 0;
    $display("test drop done");
    for (int c = 0; c < 16; c++) send_cell(8'(c), 6'h34, 1'b0);
    repeat (4) @(negedge sys_clk_i);
    check({fifo_full_o, up_ready_o}, 2'h2);
    want = 1;
    for (int c = 0; c < 16; c++) expect_cell(8'(c), 6'h34, 1'b0);
    want = 0;
    $display("test fill done");
    rx_config_i.handshake = HS_OCTET;
    repeat (8) @(negedge sys_clk_i);
    send_cell(8'ha0, 6'h34, 1'b0);
    repeat (12) @(negedge sys_clk_i);
    want = 1;
    while (i_atm_reader_model.got.size() < 3) @(negedge sys_clk_i);
    want = 0;
    repeat (12) @(negedge sys_clk_i);
    check(rx_cell_available_o, 1);
    want = 1;
    expect_cell(8'ha0, 6'h34, 1'b0);
    repeat (12) @(negedge sys_clk_i);
    check({fifo_empty_o, rx_cell_available_o}, 2'h2);
    want = 0;
    rx_config_i.handshake = HS_CELL;
    $display("test octet done");
    rx_config_i.multi_phy = 1'b1;
    rx_port_address_in_i = 5'h04;
    send_cell(8'h90, 6'h34, 1'b0);
    repeat (20) @(negedge sys_clk_i);
    check(rx_cell_available_oe_o, 0);
    rx_port_address_in_i = 5'h03;
    repeat (6) @(negedge sys_clk_i);
    check(rx_cell_available_oe_o, 1);
    want = 1;
    expect_cell(8'h90, 6'h34, 1'b0);
    $display("test multi done");
    print_verdict();
  end

  initial begin
    #1ms;
    fail_count++;
    print_verdict();
  end
endmodule : tb_top
